// File: sfh_clkgen.sv
`timescale 1ns/10ps
module sfh_clkgen (
    input  wire logic clk,
    input  wire logic rst_b,
    sfh_link_if.gen   lk
);
    typedef struct packed {
        logic [4:0] cnt;
        logic       sclk;
        logic       rise;
    } sfh_gen_t;

    sfh_gen_t   s;
    sfh_gen_t   n;
    logic [4:0] half;
    logic       fall_now;

    // Half period in clk cycles, divisor is twice the field
    always_comb
    begin
        half = (lk.div < sfh_pkg::BAUD_MIN) ? sfh_pkg::BAUD_MIN :
               (lk.div > sfh_pkg::BAUD_MAX) ? sfh_pkg::BAUD_MAX : lk.div;
        n = s;
        n.rise = 1'b0;
        fall_now = 1'b0;
        if (!lk.run)
        begin
            n.cnt  = 5'h00;
            n.sclk = 1'b0;
        end
        else if (s.cnt + 5'h01 >= half)
        begin
            n.cnt  = 5'h00;
            n.sclk = ~s.sclk;
            n.rise = ~s.sclk;
            // Fall told one cycle early: data moves with the clock, last bit stops the run
            fall_now = s.sclk;
        end
        else
        begin
            n.cnt = s.cnt + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= n;
    end

    assign lk.sclk = s.sclk;
    assign lk.rise = s.rise;
    assign lk.fall = fall_now;

    a_div_two: assert property (@(posedge clk) disable iff (!rst_b)
        lk.run && $past(lk.run) && $past(lk.run, 2) && lk.div == 5'h01 && $past(lk.div) == 5'h01
        |-> s.sclk != $past(s.sclk)) else $error("divide by two does not toggle");
endmodule

// File: sfh_flash_model.sv
`timescale 1ns/10ps
module sfh_flash_model #(
    parameter logic [31:0] DATA = 32'h1234a5c3
) (
    input  wire logic       sclk,
    input  wire logic       ncs_b,
    input  wire logic       di,
    output logic      [3:0] dq,
    output logic      [7:0] opc
);
    int         n = 0;
    logic [4:0] k;
    initial dq = 4'h0;
    initial opc = 8'h00;
    // Shifts in the command byte on the first eight rising clocks
    always @(posedge sclk)
    begin
        if (!ncs_b && n < 8)
            opc <= {opc[6:0], di};
    end
    assign k = 5'(n - 32);
    // Counts rising flash clocks within a frame
    always @(posedge sclk or posedge ncs_b)
    begin
        if (ncs_b)
            n <= 0;
        else
            n <= n + 1;
    end
    // Byte 0 first, MSB first within a byte; idle lanes toggle
    always @(negedge sclk or posedge ncs_b)
    begin
        if (ncs_b)
            dq <= ~dq;
        else if (n >= 32)
            dq[1] <= DATA[{k[4:3], ~k[2:0]}];
    end
endmodule

// File: sfh_link_if.sv
`timescale 1ns/10ps
interface sfh_link_if;
    logic        run;
    logic [4:0]  div;
    logic        rise;
    logic        fall;
    logic        sclk;
    logic        start;
    logic [1:0]  mode;
    logic        drive;
    logic [31:0] wdata;
    logic [5:0]  ncyc;
    logic [3:0]  rd_dly;
    logic [3:0]  dq_i;
    logic [3:0]  dq_o;
    logic [3:0]  dq_en;
    logic [31:0] rdata;
    logic        busy;
    logic        done;
    modport ctl (output div, start, mode, drive, wdata, ncyc, rd_dly, dq_i,
                 input sclk, dq_o, dq_en, rdata, busy, done);
    modport gen (input run, div, output rise, fall, sclk);
    modport shf (input start, mode, drive, wdata, ncyc, rd_dly, dq_i, rise, fall,
                 output run, dq_o, dq_en, rdata, busy, done);
endinterface

// File: sfh_pkg.sv
package sfh_pkg;
    // Register word indexes
    localparam logic [5:0] OFS_CTRL  = 6'h00;
    localparam logic [5:0] OFS_BAUD  = 6'h01;
    localparam logic [5:0] OFS_CSDLY = 6'h02;
    localparam logic [5:0] OFS_RDCAP = 6'h03;
    localparam logic [5:0] OFS_PROTO = 6'h04;
    localparam logic [5:0] OFS_STAT  = 6'h05;
    // Field positions
    localparam int CTRL_EN     = 0;
    localparam int CTRL_CS_LSB = 4;
    localparam int CTRL_A4     = 8;
    localparam int BAUD_LSB    = 0;
    localparam int CSD_AS_LSB  = 0;
    localparam int CSD_DE_LSB  = 4;
    localparam int CSD_SH_LSB  = 8;
    localparam int RDCAP_LSB   = 0;
    localparam int PR_IM       = 0;
    localparam int PR_WA       = 4;
    localparam int PR_WD       = 8;
    localparam int PR_RA       = 12;
    localparam int PR_RD       = 16;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_IRQ    = 1;
    // Reset values and limits
    localparam logic       CTRL_EN_RST = 1'b1;
    localparam logic [4:0] BAUD_RST    = 5'h10;
    localparam logic [4:0] BAUD_MIN    = 5'h01;
    localparam logic [4:0] BAUD_MAX    = 5'h10;
    localparam logic [4:0] SHSL_BASE   = 5'h03;
    localparam logic [6:0] BURST_MAX   = 7'h40;
    // Lane modes
    localparam logic [1:0] MODE_X1 = 2'h0;
    localparam logic [1:0] MODE_X2 = 2'h1;
    localparam logic [1:0] MODE_X4 = 2'h2;

    function automatic logic [5:0] lane_cycles(input logic [5:0] bits, input logic [1:0] mode);
        unique case (mode)
            MODE_X2: lane_cycles = bits >> 1;
            MODE_X4: lane_cycles = bits >> 2;
            default: lane_cycles = bits;
        endcase
    endfunction

    function automatic logic [31:0] byte_swap(input logic [31:0] d);
        byte_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction
endpackage

// File: sfh_shift.sv
`timescale 1ns/10ps
module sfh_shift (
    input  wire logic clk,
    input  wire logic rst_b,
    sfh_link_if.shf   lk
);
    typedef struct packed {
        logic        busy;
        logic        run;
        logic [5:0]  cnt;
        logic [31:0] sh_o;
        logic [31:0] sh_i;
        logic [1:0]  mode;
        logic        drive;
        logic [15:0] pend;
        logic        done;
    } sfh_shf_t;

    sfh_shf_t s;
    sfh_shf_t n;
    logic     sample;
    logic     waiting;

    always_comb
    begin
        n = s;
        n.done = 1'b0;
        n.pend = {s.pend[14:0], lk.rise & s.run};
        // Sampling is postponed by the read delay setting
        sample = (lk.rd_dly == 4'h0) ? (lk.rise & s.run) : s.pend[lk.rd_dly - 4'h1];
        waiting = |(s.pend & ((16'h0001 << lk.rd_dly) - 16'h0001));
        if (sample)
        begin
            unique case (s.mode)
                sfh_pkg::MODE_X2: n.sh_i = {s.sh_i[29:0], lk.dq_i[1:0]};
                sfh_pkg::MODE_X4: n.sh_i = {s.sh_i[27:0], lk.dq_i};
                default:          n.sh_i = {s.sh_i[30:0], lk.dq_i[1]};
            endcase
        end
        if (!s.busy && lk.start)
        begin
            n.busy  = 1'b1;
            n.run   = 1'b1;
            n.cnt   = lk.ncyc;
            n.sh_o  = lk.wdata;
            n.mode  = lk.mode;
            n.drive = lk.drive;
            n.pend  = 16'h0000;
        end
        else if (s.run && lk.fall)
        begin
            unique case (s.mode)
                sfh_pkg::MODE_X2: n.sh_o = s.sh_o << 2;
                sfh_pkg::MODE_X4: n.sh_o = s.sh_o << 4;
                default:          n.sh_o = s.sh_o << 1;
            endcase
            n.cnt = s.cnt - 6'h01;
            if (s.cnt == 6'h01)
                n.run = 1'b0;
        end
        else if (s.busy && !s.run && !waiting && !sample)
        begin
            n.busy = 1'b0;
            n.done = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= n;
    end

    assign lk.run   = s.run;
    assign lk.busy  = s.busy;
    assign lk.done  = s.done;
    assign lk.rdata = s.sh_i;
    assign lk.dq_o  = (s.mode == sfh_pkg::MODE_X4) ? s.sh_o[31:28] :
                      (s.mode == sfh_pkg::MODE_X2) ? {2'b00, s.sh_o[31:30]} :
                      {3'b000, s.sh_o[31]};
    assign lk.dq_en = !(s.busy && s.drive) ? 4'h0 :
                      (s.mode == sfh_pkg::MODE_X4) ? 4'hf :
                      (s.mode == sfh_pkg::MODE_X2) ? 4'h3 : 4'h1;

    a_quad_lanes: assert property (@(posedge clk) disable iff (!rst_b)
        s.busy && s.drive && s.mode == sfh_pkg::MODE_X4 |-> lk.dq_en == 4'hf)
        else $error("quad transfer not driving four lanes");
endmodule

// File: sfh_top.sv
`timescale 1ns/10ps
// How it works
// - Register port: 6-bit word address, 32-bit data
// - Read-valid marks register read data
// - Optional byte enables qualify register writes
// - Burst length 1 to 64 words
// - Word address, goes to selected chip
// - Memory read-valid marks each returned word
// - Waitrequest holds host while busy
// - Reset acts asynchronously on all state
// - Interrupt on illegal write
// - Four data lanes, clock, active-low selects
// - Flash pins always exported; EXPORT_PINS off is rejected as unsupported
// - Single, dual and quad transfers
// - Up to three chips, one select each
// - Programmable flash clock divider, live changes
// - Programmable select setup and hold delays
// - Read sampling can be postponed
// - Select field picks chip 0, 1, 2
// - Divisor 2 to 32, resets to 32
// - Enable low floats flash outputs
// - Bit 8 picks 3- or 4-byte addressing
module sfh_top #(
    parameter int         DENSITY_MB  = 256,
    parameter int         NUM_CS      = 3,
    parameter bit         USE_BYTEEN  = 1'b0,
    parameter bit         EXPORT_PINS = 1'b1,
    parameter logic [7:0] RD_OPC      = 8'h03,
    parameter logic [7:0] WR_OPC      = 8'h02,
    localparam int        AW          = $clog2(DENSITY_MB) + 15
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic [5:0]    csr_addr,
    input  wire logic          csr_read,
    input  wire logic          csr_write,
    input  wire logic [31:0]   csr_wrdata,
    input  wire logic [3:0]    csr_byteenable,
    output logic      [31:0]   csr_rdata,
    output logic               csr_waitrequest,
    output logic               csr_rddata_valid,
    input  wire logic [AW-1:0] mem_addr,
    input  wire logic          mem_read,
    input  wire logic          mem_write,
    input  wire logic [6:0]    mem_burstcount,
    input  wire logic [31:0]   mem_wrdata,
    input  wire logic [3:0]    mem_byteenable,
    output logic      [31:0]   mem_rddata,
    output logic               mem_rddata_valid,
    output logic               mem_waitrequest,
    output logic               irq,
    input  wire logic [3:0]    flash_dq_i,
    output logic      [3:0]    flash_dq_o,
    output logic      [3:0]    flash_dq_oe_b,
    output logic               flash_sclk,
    output logic               flash_sclk_oe_b,
    output logic      [2:0]    flash_ncs_b,
    output logic               flash_ncs_oe_b
);
    if (NUM_CS < 1 || NUM_CS > 3 || DENSITY_MB < 1 || DENSITY_MB > 2048 || !EXPORT_PINS)
    begin : g_bad_cfg
        $error("unsupported configuration");
    end

    typedef enum logic [3:0] {
        ST_IDLE, ST_CSSET, ST_OPC, ST_ADDR, ST_RD, ST_WR, ST_CSHOLD, ST_GAP, ST_DROP
    } sfh_state_t;

    typedef struct packed {
        sfh_state_t  st;
        logic        en;
        logic [3:0]  csel;
        logic        a4;
        logic [4:0]  baud;
        logic [3:0]  cs_as;
        logic [3:0]  cs_de;
        logic [3:0]  shsl;
        logic [3:0]  rd_dly;
        logic [1:0]  im;
        logic [1:0]  wam;
        logic [1:0]  wdm;
        logic [1:0]  ram;
        logic [1:0]  rdm;
        logic        irq;
        logic        csr_wait;
        logic [31:0] csr_rdata;
        logic        csr_rdv;
        logic        mem_wait;
        logic [31:0] mem_rdata;
        logic        mem_rdv;
        logic [4:0]  cnt;
        logic [6:0]  left;
        logic [31:0] baddr;
        logic [1:0]  cur_cs;
        logic        wr;
        logic [31:0] wbuf;
        logic        start;
        logic [1:0]  mode;
        logic        drive;
        logic [31:0] wdata;
        logic [5:0]  ncyc;
        logic [2:0]  ncs;
        logic [3:0]  dq_o;
        logic [3:0]  dq_oe_b;
        logic        sclk;
        logic        sclk_oe_b;
        logic [2:0]  ncs_b;
        logic        ncs_oe_b;
    } sfh_top_t;

    sfh_top_t   s;
    sfh_top_t   n;
    logic [1:0] rst_q;
    logic       rst_s;

    sfh_link_if lk ();

    function automatic logic [31:0] reg_word(input sfh_top_t x, input logic [5:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            sfh_pkg::OFS_CTRL:
            begin
                r[sfh_pkg::CTRL_EN] = x.en;
                r[sfh_pkg::CTRL_CS_LSB +: 4] = x.csel;
                r[sfh_pkg::CTRL_A4] = x.a4;
            end
            sfh_pkg::OFS_BAUD:  r[sfh_pkg::BAUD_LSB +: 5] = x.baud;
            sfh_pkg::OFS_CSDLY: r[11:0] = {x.shsl, x.cs_de, x.cs_as};
            sfh_pkg::OFS_RDCAP: r[sfh_pkg::RDCAP_LSB +: 4] = x.rd_dly;
            sfh_pkg::OFS_PROTO: r[17:0] = {x.rdm, 2'b00, x.ram, 2'b00, x.wdm, 2'b00,
                                           x.wam, 2'b00, x.im};
            sfh_pkg::OFS_STAT:
            begin
                r[sfh_pkg::STAT_BUSY] = x.st != ST_IDLE;
                r[sfh_pkg::STAT_IRQ] = x.irq;
            end
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++)
            if (be[i])
                o[8*i +: 8] = d[8*i +: 8];
        return o;
    endfunction

    // Asynchronous assertion, synchronised release
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_q <= 2'b00;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_s = rst_q[1];

    always_comb
    begin
        logic [31:0] w;
        logic [3:0]  be;
        w = 32'h0000_0000;
        be = USE_BYTEEN ? csr_byteenable : 4'hf;
        n = s;
        n.csr_wait = 1'b0;
        n.csr_rdv = 1'b0;
        n.mem_rdv = 1'b0;
        n.start = 1'b0;
        // Register port, one word per address
        if (csr_read)
        begin
            n.csr_rdata = reg_word(s, csr_addr);
            n.csr_rdv = 1'b1;
        end
        if (csr_write)
        begin
            w = merge(reg_word(s, csr_addr), csr_wrdata, be);
            unique case (csr_addr)
                sfh_pkg::OFS_CTRL:
                begin
                    n.en = w[sfh_pkg::CTRL_EN];
                    n.csel = w[sfh_pkg::CTRL_CS_LSB +: 4];
                    n.a4 = w[sfh_pkg::CTRL_A4];
                end
                sfh_pkg::OFS_BAUD:  n.baud = w[sfh_pkg::BAUD_LSB +: 5];
                sfh_pkg::OFS_CSDLY:
                begin
                    n.cs_as = w[sfh_pkg::CSD_AS_LSB +: 4];
                    n.cs_de = w[sfh_pkg::CSD_DE_LSB +: 4];
                    n.shsl = w[sfh_pkg::CSD_SH_LSB +: 4];
                end
                sfh_pkg::OFS_RDCAP: n.rd_dly = w[sfh_pkg::RDCAP_LSB +: 4];
                sfh_pkg::OFS_PROTO:
                begin
                    n.im = w[sfh_pkg::PR_IM +: 2];
                    n.wam = w[sfh_pkg::PR_WA +: 2];
                    n.wdm = w[sfh_pkg::PR_WD +: 2];
                    n.ram = w[sfh_pkg::PR_RA +: 2];
                    n.rdm = w[sfh_pkg::PR_RD +: 2];
                end
                sfh_pkg::OFS_STAT:
                    if (w[sfh_pkg::STAT_IRQ])
                        n.irq = 1'b0;
                default: n.irq = s.irq;
            endcase
        end
        // Byte enables are not used: bursts are whole words
        unique case (s.st)
            ST_IDLE:
            begin
                n.mem_wait = 1'b0;
                if ((mem_read || mem_write) && !s.mem_wait)
                begin
                    n.mem_wait = 1'b1;
                    n.left = mem_burstcount;
                    n.baddr = 32'({mem_addr, 2'b00});
                    n.cur_cs = s.csel[1:0];
                    n.wr = mem_write;
                    n.wbuf = sfh_pkg::byte_swap(mem_wrdata);
                    if (mem_write && (s.csel >= 4'(NUM_CS) || mem_burstcount == 7'h00 ||
                        mem_burstcount > sfh_pkg::BURST_MAX))
                    begin
                        n.irq = 1'b1;
                        n.left = mem_burstcount - 7'h01;
                        n.mem_wait = 1'b0;
                        if (mem_burstcount > 7'h01)
                            n.st = ST_DROP;
                    end
                    else
                    begin
                        n.ncs = (s.csel < 4'(NUM_CS)) ? ~(3'b001 << s.csel[1:0]) : 3'b111;
                        n.cnt = {1'b0, s.cs_as};
                        n.st = ST_CSSET;
                    end
                end
            end
            ST_DROP:
                if (mem_write)
                begin
                    n.left = s.left - 7'h01;
                    if (s.left == 7'h01)
                        n.st = ST_IDLE;
                end
            ST_CSSET:
                if (s.cnt == 5'h00)
                begin
                    n.start = 1'b1;
                    n.mode = s.im;
                    n.drive = 1'b1;
                    n.wdata = {s.wr ? WR_OPC : RD_OPC, 24'h000000};
                    n.ncyc = sfh_pkg::lane_cycles(6'd8, s.im);
                    n.st = ST_OPC;
                end
                else
                    n.cnt = s.cnt - 5'h01;
            ST_OPC:
                if (lk.done)
                begin
                    n.start = 1'b1;
                    n.mode = s.wr ? s.wam : s.ram;
                    n.wdata = s.a4 ? s.baddr : {s.baddr[23:0], 8'h00};
                    n.ncyc = sfh_pkg::lane_cycles(s.a4 ? 6'd32 : 6'd24, n.mode);
                    n.st = ST_ADDR;
                end
            ST_ADDR:
                if (lk.done)
                begin
                    n.start = 1'b1;
                    n.mode = s.wr ? s.wdm : s.rdm;
                    n.drive = s.wr;
                    n.wdata = s.wbuf;
                    n.ncyc = sfh_pkg::lane_cycles(6'd32, n.mode);
                    n.left = s.wr ? s.left - 7'h01 : s.left;
                    n.st = s.wr ? ST_WR : ST_RD;
                end
            ST_RD:
                if (lk.done)
                begin
                    n.mem_rdata = sfh_pkg::byte_swap(lk.rdata);
                    n.mem_rdv = 1'b1;
                    n.left = s.left - 7'h01;
                    if (s.left == 7'h01)
                    begin
                        n.cnt = {1'b0, s.cs_de};
                        n.st = ST_CSHOLD;
                    end
                    else
                        n.start = 1'b1;
                end
            ST_WR:
                if (s.mem_wait)
                begin
                    if (lk.done)
                    begin
                        if (s.left == 7'h00)
                        begin
                            n.cnt = {1'b0, s.cs_de};
                            n.st = ST_CSHOLD;
                        end
                        else
                            n.mem_wait = 1'b0;
                    end
                end
                else if (mem_write)
                begin
                    n.start = 1'b1;
                    n.wdata = sfh_pkg::byte_swap(mem_wrdata);
                    n.left = s.left - 7'h01;
                    n.mem_wait = 1'b1;
                end
            ST_CSHOLD:
                if (s.cnt == 5'h00)
                begin
                    n.ncs = 3'b111;
                    n.cnt = sfh_pkg::SHSL_BASE + {1'b0, s.shsl};
                    n.st = ST_GAP;
                end
                else
                    n.cnt = s.cnt - 5'h01;
            ST_GAP:
                if (s.cnt <= 5'h01)
                    n.st = ST_IDLE;
                else
                    n.cnt = s.cnt - 5'h01;
            default: n.st = ST_IDLE;
        endcase
        // Flash pins, floated when the enable bit is clear
        n.sclk = lk.sclk;
        n.dq_o = lk.dq_o;
        n.dq_oe_b = ~lk.dq_en | {4{~s.en}};
        n.sclk_oe_b = ~s.en;
        n.ncs_b = s.ncs;
        n.ncs_oe_b = ~s.en;
    end

    always_ff @(posedge clk or negedge rst_s)
    begin
        if (!rst_s)
        begin
            s <= '0;
            s.en <= sfh_pkg::CTRL_EN_RST;
            s.baud <= sfh_pkg::BAUD_RST;
            s.mem_wait <= 1'b1;
            s.ncs <= 3'b111;
            s.ncs_b <= 3'b111;
            s.dq_oe_b <= 4'hf;
            s.sclk_oe_b <= 1'b1;
            s.ncs_oe_b <= 1'b1;
        end
        else
            s <= n;
    end

    assign lk.div    = s.baud;
    assign lk.start  = s.start;
    assign lk.mode   = s.mode;
    assign lk.drive  = s.drive;
    assign lk.wdata  = s.wdata;
    assign lk.ncyc   = s.ncyc;
    assign lk.rd_dly = s.rd_dly;
    assign lk.dq_i   = flash_dq_i;

    sfh_clkgen u_gen (
        .clk   (clk),
        .rst_b (rst_s),
        .lk    (lk.gen)
    );

    sfh_shift u_shf (
        .clk   (clk),
        .rst_b (rst_s),
        .lk    (lk.shf)
    );

    assign csr_rdata        = s.csr_rdata;
    assign csr_waitrequest  = s.csr_wait;
    assign csr_rddata_valid = s.csr_rdv;
    assign mem_rddata       = s.mem_rdata;
    assign mem_rddata_valid = s.mem_rdv;
    assign mem_waitrequest  = s.mem_wait;
    assign irq              = s.irq;
    assign flash_dq_o       = s.dq_o;
    assign flash_dq_oe_b    = s.dq_oe_b;
    assign flash_sclk       = s.sclk;
    assign flash_sclk_oe_b  = s.sclk_oe_b;
    assign flash_ncs_b      = s.ncs_b;
    assign flash_ncs_oe_b   = s.ncs_oe_b;

    a_csr_rdv: assert property (@(posedge clk) disable iff (!rst_s)
        csr_read |=> csr_rddata_valid) else $error("register read without valid");
    a_mem_rdv: assert property (@(posedge clk) disable iff (!rst_s)
        mem_rddata_valid |-> $past(s.st) == ST_RD && $past(lk.done))
        else $error("memory valid outside a read word");
    a_irq_set: assert property (@(posedge clk) disable iff (!rst_s)
        s.st == ST_IDLE && mem_write && !mem_waitrequest && s.csel >= 4'(NUM_CS)
        |=> irq) else $error("illegal write not flagged");
    a_one_select: assert property (@(posedge clk) disable iff (!rst_s)
        $countones(~flash_ncs_b) <= 1) else $error("more than one select low");
    a_chip_pick: assert property (@(posedge clk) disable iff (!rst_s)
        s.st == ST_OPC && s.cur_cs == 2'h1 && NUM_CS > 1 |-> s.ncs == 3'b101)
        else $error("wrong chip selected");
    a_float_off: assert property (@(posedge clk) disable iff (!rst_s)
        !s.en |=> flash_dq_oe_b == 4'hf && flash_sclk_oe_b && flash_ncs_oe_b)
        else $error("pins driven while disabled");
    a_wait_busy: assert property (@(posedge clk) disable iff (!rst_s)
        s.st == ST_OPC || s.st == ST_ADDR || s.st == ST_RD |-> mem_waitrequest)
        else $error("waitrequest low while busy");
endmodule

// File: sfh_top_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module sfh_top_tb_top;
    logic        clk = 1'b0, rst_b = 1'b0, csr_read = 1'b0, csr_write = 1'b0;
    logic        mem_read = 1'b0, mem_write = 1'b0;
    logic [5:0]  csr_addr = 6'h00;
    logic [31:0] csr_wrdata = 32'h0, mem_wrdata = 32'h0, csr_rdata, mem_rddata;
    logic [3:0]  csr_byteenable = 4'hf, mem_byteenable = 4'hf;
    logic [22:0] mem_addr = 23'h0;
    logic [6:0]  mem_burstcount = 7'h01;
    logic        csr_waitrequest, csr_rddata_valid, mem_rddata_valid, mem_waitrequest, irq;
    logic [3:0]  flash_dq_i, flash_dq_o, flash_dq_oe_b;
    logic        flash_sclk, flash_sclk_oe_b, flash_ncs_oe_b;
    logic [2:0]  flash_ncs_b;
    logic [7:0]  opc;
    int          n_fail = 0, n_checks = 0;
    always #2 clk = ~clk;
    sfh_top sfh_top_inst (.clk, .rst_b, .csr_addr, .csr_read, .csr_write, .csr_wrdata,
        .csr_byteenable, .csr_rdata, .csr_waitrequest, .csr_rddata_valid, .mem_addr,
        .mem_read, .mem_write, .mem_burstcount, .mem_wrdata, .mem_byteenable, .mem_rddata,
        .mem_rddata_valid, .mem_waitrequest, .irq, .flash_dq_i, .flash_dq_o, .flash_dq_oe_b,
        .flash_sclk, .flash_sclk_oe_b, .flash_ncs_b, .flash_ncs_oe_b);
    sfh_flash_model sfh_flash_model_inst (.sclk(flash_sclk), .ncs_b(flash_ncs_b[0]),
        .di(flash_dq_o[0]), .dq(flash_dq_i), .opc(opc));
    task automatic finish_test;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic csr_wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        csr_addr <= a;
        csr_wrdata <= d;
        csr_write <= 1'b1;
        @(posedge clk);
        csr_write <= 1'b0;
    endtask
    task automatic csr_rd(input logic [5:0] a, input logic [31:0] exp);
        @(posedge clk);
        csr_addr <= a;
        csr_read <= 1'b1;
        @(posedge clk);
        csr_read <= 1'b0;
        #1;
        `CHK("csr_valid", csr_rddata_valid, 1'b1)
        `CHK("csr_wait", csr_waitrequest, 1'b0)
        `CHK("csr_rdata", csr_rdata, exp)
    endtask
    task automatic mem_cmd(input logic rd, input logic [6:0] bc);
        int nb;
        int i;
        nb = (rd || bc == 7'h00) ? 1 : int'(bc);
        i = 0;
        @(posedge clk);
        mem_read <= rd;
        mem_write <= !rd;
        mem_burstcount <= bc;
        mem_byteenable <= 4'hf;
        // Every write beat is held until an edge that sees waitrequest low
        while (nb > 0 && i < 2000)
        begin
            #1;
            if (!mem_waitrequest)
                nb--;
            i++;
            @(posedge clk);
        end
        mem_read <= 1'b0;
        mem_write <= 1'b0;
        `CHK("mem_beats", nb, 0)
    endtask
    task automatic t_read_word;
        int i = 0;
        csr_wr(sfh_pkg::OFS_BAUD, 32'h1);
        mem_cmd(1'b1, 7'h01);
        while (mem_rddata_valid !== 1'b1 && i++ < 2000)
        begin
            @(posedge clk);
            #1;
        end
        `CHK("mem_valid", mem_rddata_valid, 1'b1)
        `CHK("mem_rdata", mem_rddata, 32'h1234a5c3)
        `CHK("opcode", opc, 8'h03)
    endtask
    task automatic t_chip1;
        csr_wr(sfh_pkg::OFS_CTRL, 32'h11);
        mem_cmd(1'b1, 7'h01);
        repeat (2) @(posedge clk);
        #1;
        `CHK("ncs_chip1", flash_ncs_b, 3'h5)
        wait (mem_waitrequest === 1'b0);
        csr_wr(sfh_pkg::OFS_CTRL, 32'h01);
    endtask
    task automatic t_illegal(input logic [31:0] ctrl, input logic [6:0] bc);
        csr_wr(sfh_pkg::OFS_CTRL, ctrl);
        mem_cmd(1'b0, bc);
        csr_rd(sfh_pkg::OFS_STAT, 32'h2);
        `CHK("irq", irq, 1'b1)
        `CHK("ncs_idle", flash_ncs_b, 3'h7)
        `CHK("sclk_idle", flash_sclk, 1'b0)
        csr_wr(sfh_pkg::OFS_STAT, 32'h2);
        csr_rd(sfh_pkg::OFS_STAT, 32'h0);
        `CHK("irq_clr", irq, 1'b0)
    endtask
    task automatic t_float;
        csr_wr(sfh_pkg::OFS_CTRL, 32'h0);
        csr_rd(sfh_pkg::OFS_CTRL, 32'h0);
        `CHK("oe_b", {flash_sclk_oe_b, flash_ncs_oe_b, flash_dq_oe_b}, 6'h3f)
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        csr_rd(sfh_pkg::OFS_CTRL, 32'h1);
        csr_rd(sfh_pkg::OFS_BAUD, 32'h10);
        csr_rd(6'h3f, 32'h0);
        t_read_word();
        t_chip1();
        t_illegal(32'h31, 7'h01);
        t_illegal(32'h01, 7'h41);
        t_illegal(32'h01, 7'h00);
        t_float();
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end
endmodule
